// file: tmr16_timer.v
// Top of the 16-bit timer, event counter and pulse width capture block.
// Assumes the register master never waits and pins are driven by the surrounding pad logic.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "tmr16_defs.vh"

module tmr16_timer (
  input wire i_mclk,
  input wire i_rst,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [7:0] o_rdata,
  input wire i_tc_pin,
  output wire o_tc_o,
  output wire o_tc_oe_n,
  output wire o_tc_pullup_en,
  output wire o_pe0_o,
  output wire o_pe0_oe_n,
  output wire o_irq,
  output wire o_wakeup
);

  // ************************************************************
  // Constants and states
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ARMED = 3'h2;
  localparam [2:0] ST_COUNT = 3'h4;
  localparam integer LOW_SPEED_INTERNAL_OSC_LAST_I = `TMR16_LOW_SPEED_INTERNAL_OSC_DIV - 1;
  localparam integer SYS_LAST_I = `TMR16_SYS_DIV - 1;
  localparam [7:0] CTRL_RST = `TMR16_CTRL_RST;
  localparam [11:0] LOW_SPEED_INTERNAL_OSC_LAST = LOW_SPEED_INTERNAL_OSC_LAST_I[11:0];
  localparam [1:0] SYS_LAST = SYS_LAST_I[1:0];

  // ************************************************************
  // Declarations
  // ************************************************************
  reg [1:0] mode_q;
  reg clk_sel_q;
  reg run_q;
  reg run_d;
  reg edge_q;
  reg pfd_sel_q;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg [15:0] pre_q;
  reg irq_en_q;
  reg irq_flag_q;
  reg pe0_data_q;
  reg pe0_dir_q;
  reg tc_dir_q;
  reg tc_pull_q;
  reg tc_data_q;
  reg pfd_q;
  reg pe0_o_q;
  reg wake_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] sys_div_q;
  reg [11:0] low_speed_internal_osc_div_q;
  reg [7:0] rdata_q;
  reg [7:0] rd_mux;
  wire tc_level;
  wire tc_rise;
  wire tc_fall;
  wire wr_ctrl;
  wire wr_cnt_lo;
  wire wr_cnt_hi;
  wire wr_pre_lo;
  wire wr_pre_hi;
  wire wr_int;
  wire wr_port;
  wire sys_tick;
  wire low_speed_internal_osc_tick;
  wire int_tick;
  wire mode_timer;
  wire mode_event;
  wire mode_cap;
  wire ev_edge;
  wire cap_start;
  wire cap_end;
  wire cap_done;
  wire count_en;
  wire ovf;

  // Picks the falling pulse when pick is high, otherwise the rising pulse.
  function sel_edge;
    input pick;
    input rise;
    input fall;
    begin
      sel_edge = pick ? fall : rise;
    end
  endfunction

  // ************************************************************
  // Input synchroniser
  // ************************************************************
  tmr16_edge_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pin(i_tc_pin),
    .o_level(tc_level),
    .o_rise(tc_rise),
    .o_fall(tc_fall)
  );

  // ************************************************************
  // Register decode
  // ************************************************************
  // One write strobe per register.
  assign wr_ctrl = i_wr & (i_addr == `TMR16_OFS_CTRL);
  assign wr_cnt_lo = i_wr & (i_addr == `TMR16_OFS_CNT_LO);
  assign wr_cnt_hi = i_wr & (i_addr == `TMR16_OFS_CNT_HI);
  assign wr_pre_lo = i_wr & (i_addr == `TMR16_OFS_PRE_LO);
  assign wr_pre_hi = i_wr & (i_addr == `TMR16_OFS_PRE_HI);
  assign wr_int = i_wr & (i_addr == `TMR16_OFS_INTERRUPT_CONTROL_THREE);
  assign wr_port = i_wr & (i_addr == `TMR16_OFS_PORT);

  // ************************************************************
  // Internal clock sources
  // ************************************************************
  // System clock divided by four and the low-speed oscillator model.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      sys_div_q <= 2'h0;
      low_speed_internal_osc_div_q <= 12'h000;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
      if (low_speed_internal_osc_div_q == LOW_SPEED_INTERNAL_OSC_LAST) begin
        low_speed_internal_osc_div_q <= 12'h000;
      end else begin
        low_speed_internal_osc_div_q <= low_speed_internal_osc_div_q + 12'h001;
      end
    end
  end

  // A tick marks the falling edge of each divided clock.
  assign sys_tick = (sys_div_q == SYS_LAST);
  assign low_speed_internal_osc_tick = (low_speed_internal_osc_div_q == LOW_SPEED_INTERNAL_OSC_LAST);
  assign int_tick = clk_sel_q ? low_speed_internal_osc_tick : sys_tick;

  // ************************************************************
  // Mode decode and counting enables
  // ************************************************************
  assign mode_timer = (mode_q == `TMR16_MODE_TIMER);
  assign mode_event = (mode_q == `TMR16_MODE_EVENT);
  assign mode_cap = (mode_q == `TMR16_MODE_CAPTURE);

  // Event edge and capture edges from the edge-select bit.
  assign ev_edge = sel_edge(edge_q, tc_rise, tc_fall);
  assign cap_start = sel_edge(~edge_q, tc_rise, tc_fall);
  assign cap_end = sel_edge(edge_q, tc_rise, tc_fall);

  // The returning edge stops the count and drops the run bit.
  assign cap_done = mode_cap & run_q & (state_q == ST_COUNT) & cap_end;

  // Nothing here is gated by sleep, so event counting carries on in idle.
  assign count_en = (mode_timer & run_q & int_tick)
                  | (mode_event & run_q & ev_edge)
                  | (mode_cap & run_q & (state_q == ST_COUNT) & ~cap_end & int_tick);

  // Overflow happens on the step past all ones.
  assign ovf = count_en & (cnt_q == `TMR16_CNT_FULL);

  // ************************************************************
  // Capture sequencer
  // ************************************************************
  // Idle until armed, wait for the start edge, count until the return edge.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (mode_cap & run_q) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (~mode_cap | ~run_q) begin
          state_d = ST_IDLE;
        end else if (cap_start) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (~mode_cap | ~run_q | cap_end) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Run bit: software writes win, the capture end clears it otherwise.
  always @* begin
    run_d = run_q;
    if (wr_ctrl) begin
      run_d = i_wdata[`TMR16_CTRL_RUN];
    end else if (cap_done) begin
      run_d = 1'b0;
    end
  end

  // ************************************************************
  // Counter next value
  // ************************************************************
  // Direct byte writes first, then preload loads, then overflow reload, then increment.
  always @* begin
    cnt_d = cnt_q;
    if (wr_cnt_lo) begin
      cnt_d = {cnt_q[15:8], i_wdata};
    end else if (wr_cnt_hi) begin
      cnt_d = {i_wdata, cnt_q[7:0]};
    end else if (wr_pre_lo & ~run_q) begin
      cnt_d = {pre_q[15:8], i_wdata};
    end else if (wr_pre_hi & ~run_q) begin
      cnt_d = {i_wdata, pre_q[7:0]};
    end else if (ovf) begin
      cnt_d = pre_q;
    end else if (count_en) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  // ************************************************************
  // Registers and state
  // ************************************************************
  always @(posedge i_mclk) begin
    if (i_rst) begin
      mode_q <= CTRL_RST[`TMR16_CTRL_MODE_HI:`TMR16_CTRL_MODE_LO];
      clk_sel_q <= 1'b0;
      run_q <= 1'b0;
      edge_q <= CTRL_RST[`TMR16_CTRL_EDGE];
      pfd_sel_q <= 1'b0;
      cnt_q <= 16'h0000;
      pre_q <= 16'h0000;
      irq_en_q <= 1'b0;
      irq_flag_q <= 1'b0;
      pe0_data_q <= 1'b0;
      pe0_dir_q <= 1'b1;
      tc_dir_q <= 1'b1;
      tc_pull_q <= 1'b0;
      tc_data_q <= 1'b0;
      pfd_q <= 1'b0;
      state_q <= ST_IDLE;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      state_q <= state_d;
      if (wr_ctrl) begin
        mode_q <= i_wdata[`TMR16_CTRL_MODE_HI:`TMR16_CTRL_MODE_LO];
        clk_sel_q <= i_wdata[`TMR16_CTRL_CLK_SEL];
        edge_q <= i_wdata[`TMR16_CTRL_EDGE];
        pfd_sel_q <= i_wdata[`TMR16_CTRL_PFD_SEL];
      end
      // A running counter picks up the new preload at its next overflow.
      if (wr_pre_lo) begin
        pre_q[7:0] <= i_wdata;
      end
      if (wr_pre_hi) begin
        pre_q[15:8] <= i_wdata;
      end
      if (wr_int) begin
        irq_en_q <= i_wdata[`TMR16_INT_EN];
      end
      // An overflow in the same cycle as a clear still sets the flag.
      if (ovf) begin
        irq_flag_q <= 1'b1;
      end else if (wr_int) begin
        irq_flag_q <= i_wdata[`TMR16_INT_FLAG];
      end
      if (wr_port) begin
        pe0_data_q <= i_wdata[`TMR16_PORT_PE0_DATA];
        pe0_dir_q <= i_wdata[`TMR16_PORT_PE0_DIR];
        tc_dir_q <= i_wdata[`TMR16_PORT_TC_DIR];
        tc_pull_q <= i_wdata[`TMR16_PORT_TC_PULL];
        tc_data_q <= i_wdata[`TMR16_PORT_TC_DATA];
      end
      if (ovf) begin
        pfd_q <= ~pfd_q;
      end
    end
  end

  // ************************************************************
  // Pin and event outputs
  // ************************************************************
  // Divider pin value and wake pulse come from flip-flops.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      pe0_o_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      pe0_o_q <= pfd_sel_q ? (pfd_q & pe0_data_q) : pe0_data_q;
      wake_q <= ovf;
    end
  end

  assign o_pe0_o = pe0_o_q;
  assign o_pe0_oe_n = pe0_dir_q; // Low drives the divider pin.
  assign o_tc_o = tc_data_q;
  assign o_tc_oe_n = tc_dir_q; // High leaves the timer pin as an input.
  assign o_tc_pullup_en = tc_pull_q;
  assign o_irq = irq_flag_q & irq_en_q;
  assign o_wakeup = wake_q;

  // ************************************************************
  // Read port
  // ************************************************************
  // Unmapped offsets and reserved bits read as zero.
  always @* begin
    rd_mux = 8'h00;
    case (i_addr)
      `TMR16_OFS_CTRL: begin
        rd_mux = {mode_q, clk_sel_q, run_q, edge_q, pfd_sel_q, 2'h0};
      end
      `TMR16_OFS_CNT_LO: begin
        rd_mux = cnt_q[7:0];
      end
      `TMR16_OFS_CNT_HI: begin
        rd_mux = cnt_q[15:8];
      end
      `TMR16_OFS_PRE_LO: begin
        rd_mux = pre_q[7:0];
      end
      `TMR16_OFS_PRE_HI: begin
        rd_mux = pre_q[15:8];
      end
      `TMR16_OFS_INTERRUPT_CONTROL_THREE: begin
        rd_mux = {6'h00, irq_flag_q, irq_en_q};
      end
      `TMR16_OFS_PORT: begin
        rd_mux = {2'h0, tc_level, tc_data_q, tc_pull_q, tc_dir_q, pe0_dir_q, pe0_data_q};
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;

endmodule // tmr16_timer

// file: tmr16_defs.vh
// Constants for the 16-bit timer, event counter and pulse width capture block.
// Assumes an 8-bit register port and one 100 MHz system clock.
//
// How it works
// - Mode field one-zero selects interval timer.
// - Timer counts falling edges of internal clock.
// - Timer overflow: request, reload, keep counting.
// - Overflow request gated by enable; also wakes.
// - Mode zero-one counts external input edges.
// - Edge bit low rising, high falling.
// - Run bit starts; only software clears normally.
// - Event counting continues in sleep, wakes.
// - Mode one-one captures on internal clock.
// - Capture: run arms; active edge starts.
// - Edge bit picks falling-start or rising-start.
// - Capture end clears run bit automatically.
// - Captured value holds; edges ignored until rearm.
// - Capture overflow: request, reload, continue.
// - Divider output toggles on every overflow.
// - Divider pin output; data bit low forces low.
// - Pull-high on timer pin stays active.
// - Count up from preload to all ones.
// - Preload loads counter only while stopped.
// - Control bit 2 selects divider pin role.
`ifndef TMR16_DEFS_VH
`define TMR16_DEFS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define TMR16_OFS_CTRL 3'h0
`define TMR16_OFS_CNT_LO 3'h1
`define TMR16_OFS_CNT_HI 3'h2
`define TMR16_OFS_PRE_LO 3'h3
`define TMR16_OFS_PRE_HI 3'h4
`define TMR16_OFS_INTERRUPT_CONTROL_THREE 3'h5
`define TMR16_OFS_PORT 3'h6

// ************************************************************
// Field positions
// ************************************************************
`define TMR16_CTRL_MODE_HI 7
`define TMR16_CTRL_MODE_LO 6
`define TMR16_CTRL_CLK_SEL 5
`define TMR16_CTRL_RUN 4
`define TMR16_CTRL_EDGE 3
`define TMR16_CTRL_PFD_SEL 2
`define TMR16_INT_EN 0
`define TMR16_INT_FLAG 1
`define TMR16_PORT_PE0_DATA 0
`define TMR16_PORT_PE0_DIR 1
`define TMR16_PORT_TC_DIR 2
`define TMR16_PORT_TC_PULL 3
`define TMR16_PORT_TC_DATA 4

// ************************************************************
// Reset values and mode codes
// ************************************************************
`define TMR16_CTRL_RST 8'h08
`define TMR16_PORT_RST 8'h06
`define TMR16_MODE_EVENT 2'h1
`define TMR16_MODE_TIMER 2'h2
`define TMR16_MODE_CAPTURE 2'h3
`define TMR16_CNT_FULL 16'hFFFF

// ************************************************************
// Timing counts
// ************************************************************
`define TMR16_MCLK_HZ 100000000
`define TMR16_LOW_SPEED_INTERNAL_OSC_HZ 32000
`define TMR16_LOW_SPEED_INTERNAL_OSC_DIV (`TMR16_MCLK_HZ / `TMR16_LOW_SPEED_INTERNAL_OSC_HZ)
`define TMR16_SYS_DIV 4

`endif

// file: tmr16_edge_sync.v
// Two-stage synchroniser with edge detection for the timer input pin.
// Assumes the pin may change at any time relative to i_mclk.
`timescale 1ns/1ps

module tmr16_edge_sync (
  input wire i_mclk,
  input wire i_rst,
  input wire i_pin,
  output wire o_level,
  output wire o_rise,
  output wire o_fall
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  // Only sync_q reads the first stage; edges come from the second and third stages.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge pulses last one cycle each.
  assign o_level = sync_q;
  assign o_rise = sync_q & ~last_q;
  assign o_fall = ~sync_q & last_q;

endmodule // tmr16_edge_sync

// file: tmr16_timer_props.sv
// Port checker for the 16-bit timer block.
// Assumes it is bound to tmr16_timer and sees only that module's ports.
`timescale 1ns/1ps
module tmr16_timer_props (
  input wire i_mclk,
  input wire i_rst,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_pe0_o,
  input wire o_irq,
  input wire o_wakeup
);
  reg [7:0] ctrl_q;
  reg pe0_q;
  reg en_q;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // Shadows the bits that only software writes, so outputs can be tied to them.
  always @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_q <= 8'h08;
      pe0_q <= 1'b0;
      en_q <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == 3'h0) ctrl_q <= i_wdata;
      if (i_addr == 3'h6) pe0_q <= i_wdata[0];
      if (i_addr == 3'h5) en_q <= i_wdata[0];
    end
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  a_ctrl_readback: assert property ($past(i_rd) && $past(i_addr) == 3'h0 |->
    {o_rdata[7:5], o_rdata[3:0]} == {ctrl_q[7:5], ctrl_q[3:2], 2'b00}) else $error("control readback wrong");
  a_wake_single: assert property (o_wakeup |=> !o_wakeup) else $error("wake pulse too long");
  a_irq_gated: assert property (o_irq |-> en_q) else $error("request while disabled");
  // The flag and the wake pulse both leave flip-flops at the overflow edge, so they show together.
  a_irq_cause: assert property ($rose(o_irq) && !$past(i_wr) |->
    o_wakeup) else $error("request without overflow");
  a_pe0_gate: assert property (!pe0_q && !$past(pe0_q) |-> !o_pe0_o) else $error("divider pin not low");
  a_pe0_plain: assert property (!$past(ctrl_q[2]) |-> o_pe0_o == $past(pe0_q)) else $error("plain pin wrong");
  // The divider pin follows the toggle one cycle later, so it changes a cycle after the wake pulse.
  a_pfd_toggle: assert property ($past(ctrl_q[2], 2) && $past(ctrl_q[2]) && $past(pe0_q, 2) && $past(pe0_q)
    |-> $changed(o_pe0_o) == $past(o_wakeup)) else $error("divider toggle mismatch");
endmodule // tmr16_timer_props

bind tmr16_timer tmr16_timer_props chk_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pe0_o(o_pe0_o), .o_irq(o_irq), .o_wakeup(o_wakeup));

// file: tmr16_pulse_src.sv
// Model of the signal source on the timer input pin.
// Assumes the pin is set up as an input, so this source owns the wire.
`timescale 1ns/1ps
module tmr16_pulse_src (
  input wire i_mclk,
  output logic o_pin
);
  // Idles high like a pulled-up line.
  initial o_pin = 1'b1;
  // Holds a level for n clock cycles, changing just after an edge.
  task automatic drive(input logic lvl, input int n);
    @(posedge i_mclk);
    o_pin <= lvl;
    repeat (n - 1) @(posedge i_mclk);
  endtask
endmodule // tmr16_pulse_src

// file: test_timer16_event_capture_pfd.sv
// Self-checking bench for the 16-bit timer, event counter and capture block.
// Assumes the pulse source model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_timer16_event_capture_pfd;
  logic i_mclk;
  logic i_rst;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  wire [7:0] o_rdata;
  wire tc_pin;
  wire src_pin;
  wire tc_o;
  wire tc_oe_n;
  wire pull_en;
  wire pe0_oe_n;
  wire o_irq;
  wire pe0_o;
  wire wake;
  int wake_cnt = 0;
  int k;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] rnd = 16'h863C;
  logic [7:0] d;
  logic [15:0] v;
  int n;
  int w;

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // The source owns the wire unless the block drives it.
  assign tc_pin = tc_oe_n ? src_pin : tc_o;
  tmr16_pulse_src src_u (.i_mclk(i_mclk), .o_pin(src_pin));
  tmr16_timer dut_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_tc_pin(tc_pin), .o_tc_o(tc_o), .o_tc_oe_n(tc_oe_n), .o_tc_pullup_en(pull_en),
    .o_pe0_o(pe0_o), .o_pe0_oe_n(pe0_oe_n), .o_irq(o_irq), .o_wakeup(wake)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Builds a control byte from mode, clock source, run, edge and divider select.
  function automatic logic [7:0] ctl(input logic [1:0] m, input logic s, r, e, p);
    return {m, s, r, e, p, 2'b00};
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= x;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Counts wake pulses, which come with every overflow whatever the enable.
  always @(posedge i_mclk) begin
    if (wake === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
  // Cuts a hang short.
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    // Reset values and the unmapped offset.
    rd(3'h0, d);
    chk("ctrl", 16'h08, d);
    rd(3'h6, d);
    chk("port", 16'h26, d);
    rd(3'h7, d);
    chk("unmapped", 16'h00, d);
    // Random preloads written while stopped reach the counter.
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(3'h3, rnd[7:0]);
      wr(3'h4, rnd[15:8]);
      rd(3'h1, d);
      chk("cnt_lo", rnd[7:0], d);
      rd(3'h2, d);
      chk("cnt_hi", rnd[15:8], d);
    end
    // Interval timer from FFFE with the divider on its pin, then masked.
    wr(3'h3, 8'hFE);
    wr(3'h4, 8'hFF);
    wr(3'h5, 8'h01);
    wr(3'h6, 8'h0D);
    wr(3'h0, ctl(2'h2, 0, 1, 0, 1));
    n = 0;
    while (o_irq !== 1'b1 && n < 20) begin
      @(negedge i_mclk);
      n++;
    end
    chk("irq", 16'h1, o_irq);
    chk("pe0_oe_n", 16'h0, pe0_oe_n);
    chk("pullup", 16'h1, pull_en);
    rd(3'h2, d);
    chk("reload", 16'hFF, d);
    k = wake_cnt;
    wr(3'h5, 8'h00);
    repeat (16) @(negedge i_mclk);
    chk("masked", 16'h0, o_irq);
    chk("wake", 16'h1, wake_cnt > k);
    rd(3'h5, d);
    chk("flag", 16'h02, d);
    // A cleared data bit holds the divider pin low while overflows go on.
    wr(3'h6, 8'h1C);
    repeat (16) @(negedge i_mclk);
    chk("pe0_low", 16'h0, pe0_o);
    chk("tc_o", 16'h1, tc_o);
    // On the slow clock a preload write while running leaves the counter alone.
    wr(3'h0, 8'h00);
    wr(3'h3, 8'hF0);
    wr(3'h4, 8'hFF);
    wr(3'h0, ctl(2'h2, 1, 1, 0, 0));
    wr(3'h4, 8'h00);
    rd(3'h2, d);
    chk("no_load", 16'hFF, d);
    rd(3'h0, d);
    chk("run_kept", ctl(2'h2, 1, 1, 0, 0), d);
    // Edge counting on both edges, ending on a low level.
    for (int e = 0; e < 2; e++) begin
      wr(3'h0, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h4, 8'h00);
      src_u.drive(1'b1, 6);
      wr(3'h0, ctl(2'h1, 0, 1, e[0], 0));
      rnd = lfsr(rnd);
      n = 1 + rnd[2:0];
      repeat (n) begin
        src_u.drive(1'b0, 6);
        src_u.drive(1'b1, 6);
      end
      src_u.drive(1'b0, 6);
      rd(3'h1, d);
      chk("events", n + e, d);
    end
    // One-shot pulse capture for both start edges.
    for (int e = 0; e < 2; e++) begin
      wr(3'h0, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h4, 8'h00);
      src_u.drive(~e[0], 6);
      wr(3'h0, ctl(2'h3, 0, 1, e[0], 0));
      rnd = lfsr(rnd);
      w = 40 + rnd[4:0];
      src_u.drive(e[0], w);
      src_u.drive(~e[0], 8);
      rd(3'h0, d);
      chk("run_clear", ctl(2'h3, 0, 0, e[0], 0), d);
      rd(3'h1, d);
      v = d;
      chk("width", 16'h1, (v + 1 >= w / 4) && (v <= w / 4 + 1));
      src_u.drive(e[0], 12);
      src_u.drive(~e[0], 8);
      rd(3'h1, d);
      chk("held", v, d);
    end
    close_out();
  end
endmodule // test_timer16_event_capture_pfd
